// ===== design/hold_reset_defines.vh
`ifndef HOLD_RESET_DEFINES_VH
`define HOLD_RESET_DEFINES_VH

// Clock and timing
`define CLK_HZ              125000000
`define SEC_TICKS           (`CLK_HZ)
`define SEC_CNT_W           27
`define DEBOUNCE_MS         10
`define DEBOUNCE_TICKS      ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define DEB_CNT_W           21
`define HOLD_W              5
`define HOLD_COUNT_START    5'h01
`define HOLD_RE_SECS        5'h05
`define HOLD_CR_SECS        5'h0a
`define HOLD_FR_SECS        5'h0f
`define HOLD_MAX            5'h1f
`define BOOT_TIMEOUT_SECS   5'h1e
`define VERSION_SHOW_SECS   5'h02

// Register map (byte addresses)
`define ADDR_W              8
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_EVENT           8'h08
`define REG_LOG             8'h0c
`define REG_DISPLAY         8'h10
`define REG_VERSION         8'h14
`define REG_IPADDR          8'h18
`define REG_ID              8'h1c

// Identity value, arbitrary
`define ID_VALUE            32'h5a3c_0001

// Control register fields
`define CTRL_OS_RUN_BIT     0
`define CTRL_IP_SET_BIT     1
`define CTRL_BOOT_OK_BIT    2
`define CTRL_STARTUP_LSB    4
`define CTRL_RESET_VAL      32'h0000_0000

// Application states
`define APP_STOP            2'h0
`define APP_RUN             2'h1
`define APP_LOGIC_STOP      2'h2
`define APP_ERROR           2'h3

// Action codes
`define ACT_NONE            2'h0
`define ACT_CLEAR_EXC       2'h1
`define ACT_CONFIG          2'h2
`define ACT_FACTORY         2'h3

// Display mode codes
`define DISP_BLANK                   4'h0
`define DISP_COUNTDOWN               4'h1
`define DISP_PENDING_MODULE_RESET    4'h2
`define DISP_PENDING_CONFIG_RESET    4'h3
`define DISP_PENDING_FACTORY_RESTORE 4'h4
`define DISP_SCROLL_POINT            4'h5
`define DISP_VERSION                 4'h6
`define DISP_IP                      4'h7
`define DISP_AUTO_ADDRESS            4'h8
`define DISP_BOOT_ERROR              4'h9

// Response codes
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== design/hold_time_reset_selector.v
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "hold_reset_defines.vh"

module hold_time_reset_selector
#(
  parameter SEC_LEN = `SEC_TICKS,
  parameter DEB_LEN = `DEBOUNCE_TICKS
)
(
  input  wire        mclk,
  input  wire        rstn,
  input  wire        button_n,
  input  wire        enable_switch,
  input  wire        card_present,
  input  wire        image_present,
  input  wire        key_valid,
  input  wire        auth_done,
  input  wire        auth_ok,
  input  wire [1:0]  app_state_in,
  input  wire        app_stopped_ack,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         error_led,
  output reg  [3:0]  display_mode,
  output reg  [2:0]  display_digit,
  output reg         app_halt_req,
  output reg         app_store_req,
  output reg         restore_defaults,
  output reg         delete_user_files,
  output reg         module_reset,
  output reg         stay_stopped,
  output reg  [1:0]  app_state_set,
  output reg         app_state_set_valid,
  output reg         log_valid,
  output reg  [1:0]  log_action
);

  localparam ST_IDLE    = 3'h0;
  localparam ST_HELD    = 3'h1;
  localparam ST_HALT    = 3'h2;
  localparam ST_RESTORE = 3'h3;
  localparam ST_RESET   = 3'h4;

  localparam BT_CHECK   = 3'h0;
  localparam BT_AUTH    = 3'h1;
  localparam BT_BOOT    = 3'h2;
  localparam BT_VERSION = 3'h3;
  localparam BT_RUN     = 3'h4;
  localparam BT_HALTED  = 3'h5;

  function app_active;
    input [1:0] st;
    begin
      app_active = (st == `APP_RUN) || (st == `APP_LOGIC_STOP);
    end
  endfunction

  // Countdown digit: 4 at one second past a stage start, down to 1
  function [2:0] count_digit;
    input [`HOLD_W-1:0] secs;
    input [`HOLD_W-1:0] base;
    begin
      count_digit = 3'h5 - secs[2:0] + base[2:0];
    end
  endfunction

  reg [31:0]            ctrl_reg;
  reg [31:0]            event_reg;
  reg [31:0]            ipaddr_reg;
  reg [7:0]             log_count_reg;
  reg                   btn_meta_reg;
  reg                   btn_sync_reg;
  reg                   btn_deb_reg;
  reg [`DEB_CNT_W-1:0]  deb_cnt_reg;
  reg [`SEC_CNT_W-1:0]  sec_cnt_reg;
  reg                   sec_tick_reg;
  reg [`HOLD_W-1:0]     hold_reg;
  reg [2:0]             state_reg;
  reg [1:0]             action_reg;
  reg [2:0]             boot_reg;
  reg [`HOLD_W-1:0]     boot_secs_reg;
  reg                   boot_err_reg;
  reg                   wr_aw_reg;
  reg                   wr_w_reg;
  reg [7:0]             wr_addr_reg;
  reg [31:0]            wr_data_reg;

  wire pressed = btn_deb_reg & enable_switch;

  // Metastability filter, then a hold-off counter so bounces are not seen as releases
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      btn_meta_reg <= 1'b0;
      btn_sync_reg <= 1'b0;
      btn_deb_reg  <= 1'b0;
      deb_cnt_reg  <= {`DEB_CNT_W{1'b0}};
      sec_cnt_reg  <= {`SEC_CNT_W{1'b0}};
      sec_tick_reg <= 1'b0;
    end
    else
    begin
      btn_meta_reg <= ~button_n;
      btn_sync_reg <= btn_meta_reg;
      if (btn_sync_reg == btn_deb_reg)
        deb_cnt_reg <= {`DEB_CNT_W{1'b0}};
      else if (deb_cnt_reg == DEB_LEN - 1)
      begin
        btn_deb_reg <= btn_sync_reg;
        deb_cnt_reg <= {`DEB_CNT_W{1'b0}};
      end
      else
        deb_cnt_reg <= deb_cnt_reg + 1'b1;
      if (sec_cnt_reg == SEC_LEN - 1)
      begin
        sec_cnt_reg  <= {`SEC_CNT_W{1'b0}};
        sec_tick_reg <= 1'b1;
      end
      else
      begin
        sec_cnt_reg  <= sec_cnt_reg + 1'b1;
        sec_tick_reg <= 1'b0;
      end
    end
  end

  // Pushbutton action sequencer
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg         <= ST_IDLE;
      hold_reg          <= {`HOLD_W{1'b0}};
      action_reg        <= `ACT_NONE;
      app_halt_req      <= 1'b0;
      app_store_req     <= 1'b0;
      restore_defaults  <= 1'b0;
      delete_user_files <= 1'b0;
      module_reset      <= 1'b0;
      stay_stopped      <= 1'b0;
      log_valid         <= 1'b0;
      log_action        <= `ACT_NONE;
      log_count_reg     <= 8'h00;
    end
    else
    begin
      log_valid <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          hold_reg <= {`HOLD_W{1'b0}};
          if (pressed && boot_reg == BT_RUN)
            state_reg <= ST_HELD;
        end
        ST_HELD:
        begin
          if (pressed)
          begin
            if (sec_tick_reg && hold_reg != `HOLD_MAX)
              hold_reg <= hold_reg + 1'b1;
          end
          else
          begin
            // Release: strength chosen by the last pending code reached
            if (hold_reg >= `HOLD_FR_SECS)
              action_reg <= `ACT_FACTORY;
            else if (hold_reg >= `HOLD_CR_SECS)
              action_reg <= `ACT_CONFIG;
            else if (hold_reg >= `HOLD_RE_SECS)
              action_reg <= `ACT_CLEAR_EXC;
            else
              action_reg <= `ACT_NONE;
            if (hold_reg >= `HOLD_RE_SECS)
              state_reg <= ST_HALT;
            else
              state_reg <= ST_IDLE;
          end
        end
        ST_HALT:
        begin
          if (log_count_reg == 8'h00 || !app_halt_req)
          begin
            log_valid     <= 1'b1;
            log_action    <= action_reg;
            log_count_reg <= log_count_reg + 1'b1;
          end
          if (app_active(app_state_in) && !app_stopped_ack)
          begin
            app_halt_req  <= 1'b1;
            app_store_req <= (action_reg != `ACT_CLEAR_EXC);
          end
          else
          begin
            app_halt_req <= 1'b0;
            state_reg    <= (action_reg == `ACT_CLEAR_EXC) ? ST_RESET : ST_RESTORE;
          end
        end
        ST_RESTORE:
        begin
          restore_defaults  <= 1'b1;
          delete_user_files <= (action_reg == `ACT_FACTORY);
          stay_stopped      <= 1'b1;
          state_reg         <= ST_RESET;
        end
        ST_RESET:
        begin
          module_reset <= 1'b1;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Startup sequence and front display
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_reg            <= BT_CHECK;
      boot_secs_reg       <= {`HOLD_W{1'b0}};
      boot_err_reg        <= 1'b0;
      error_led           <= 1'b1;
      display_mode        <= `DISP_BLANK;
      display_digit       <= 3'h0;
      app_state_set       <= `APP_STOP;
      app_state_set_valid <= 1'b0;
    end
    else
    begin
      app_state_set_valid <= 1'b0;
      case (boot_reg)
        BT_CHECK:
        begin
          if (card_present && image_present && key_valid)
            boot_reg <= BT_AUTH;
          else
            boot_reg <= BT_CHECK;
        end
        BT_AUTH:
        begin
          if (auth_done && auth_ok)
          begin
            boot_reg      <= BT_BOOT;
            error_led     <= 1'b0;
            boot_secs_reg <= {`HOLD_W{1'b0}};
          end
          else if (auth_done)
            boot_reg <= BT_HALTED;
        end
        BT_BOOT:
        begin
          display_mode <= `DISP_SCROLL_POINT;
          if (ctrl_reg[`CTRL_OS_RUN_BIT])
          begin
            boot_reg      <= BT_VERSION;
            boot_secs_reg <= {`HOLD_W{1'b0}};
          end
          else if (boot_secs_reg >= `BOOT_TIMEOUT_SECS)
          begin
            boot_err_reg <= 1'b1;
            boot_reg     <= BT_HALTED;
          end
          else if (sec_tick_reg)
            boot_secs_reg <= boot_secs_reg + 1'b1;
        end
        BT_VERSION:
        begin
          display_mode <= `DISP_VERSION;
          // Tick is free-running, so one extra tick guarantees the full show time
          if (boot_secs_reg > `VERSION_SHOW_SECS)
          begin
            boot_reg            <= BT_RUN;
            app_state_set       <= ctrl_reg[`CTRL_STARTUP_LSB+1:`CTRL_STARTUP_LSB];
            app_state_set_valid <= 1'b1;
          end
          else if (sec_tick_reg)
            boot_secs_reg <= boot_secs_reg + 1'b1;
        end
        BT_RUN:
        begin
          display_digit <= 3'h0;
          if (state_reg == ST_HELD && hold_reg >= `HOLD_FR_SECS)
            display_mode <= `DISP_PENDING_FACTORY_RESTORE;
          else if (state_reg == ST_HELD && hold_reg > `HOLD_CR_SECS)
          begin
            display_mode  <= `DISP_COUNTDOWN;
            display_digit <= count_digit(hold_reg, `HOLD_CR_SECS);
          end
          else if (state_reg == ST_HELD && hold_reg == `HOLD_CR_SECS)
            display_mode <= `DISP_PENDING_CONFIG_RESET;
          else if (state_reg == ST_HELD && hold_reg > `HOLD_RE_SECS)
          begin
            display_mode  <= `DISP_COUNTDOWN;
            display_digit <= count_digit(hold_reg, `HOLD_RE_SECS);
          end
          else if (state_reg == ST_HELD && hold_reg == `HOLD_RE_SECS)
            display_mode <= `DISP_PENDING_MODULE_RESET;
          else if (state_reg == ST_HELD && hold_reg >= `HOLD_COUNT_START)
          begin
            display_mode  <= `DISP_COUNTDOWN;
            display_digit <= count_digit(hold_reg, {`HOLD_W{1'b0}});
          end
          else if (ctrl_reg[`CTRL_IP_SET_BIT])
            display_mode <= `DISP_IP;
          else
            display_mode <= `DISP_AUTO_ADDRESS;
        end
        BT_HALTED:
        begin
          error_led    <= 1'b1;
          display_mode <= boot_err_reg ? `DISP_BOOT_ERROR : `DISP_BLANK;
        end
        default:
          boot_reg <= BT_CHECK;
      endcase
    end
  end

  // AXI4-Lite slave: one access per channel pair, answer one cycle after both halves
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      wr_aw_reg     <= 1'b0;
      wr_w_reg      <= 1'b0;
      wr_addr_reg   <= 8'h00;
      wr_data_reg   <= 32'h0000_0000;
      ctrl_reg      <= `CTRL_RESET_VAL;
      ipaddr_reg    <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !wr_aw_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !wr_w_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        wr_aw_reg   <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wr_w_reg    <= 1'b1;
        wr_data_reg <= s_axi_wdata;
      end
      if (wr_aw_reg && wr_w_reg && !s_axi_bvalid)
      begin
        wr_aw_reg    <= 1'b0;
        wr_w_reg     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (wr_addr_reg == `REG_CTRL)
          ctrl_reg <= wr_data_reg;
        else if (wr_addr_reg == `REG_IPADDR)
          ipaddr_reg <= wr_data_reg;
        else if (wr_addr_reg != `REG_EVENT)
          s_axi_bresp <= `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Defaults restored on configuration or factory action
      if (restore_defaults)
      begin
        ctrl_reg   <= `CTRL_RESET_VAL;
        ipaddr_reg <= 32'h0000_0000;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL:    s_axi_rdata <= ctrl_reg;
          `REG_STATUS:  s_axi_rdata <= {20'h0_0000, boot_err_reg, error_led, boot_reg,
                                        state_reg, action_reg, app_halt_req, module_reset};
          `REG_EVENT:   s_axi_rdata <= event_reg;
          `REG_LOG:     s_axi_rdata <= {22'h00_0000, log_action, log_count_reg};
          `REG_DISPLAY: s_axi_rdata <= {25'h000_0000, display_digit, display_mode};
          `REG_VERSION: s_axi_rdata <= 32'h0000_0000;
          `REG_IPADDR:  s_axi_rdata <= ipaddr_reg;
          `REG_ID:      s_axi_rdata <= `ID_VALUE;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Event word: live hold seconds (cleared in idle) and action chosen at the last release
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      event_reg <= 32'h0000_0000;
    else
      event_reg <= {25'h000_0000, hold_reg, action_reg};
  end

endmodule

// ===== sim/hold_reset_assertions.sv
`timescale 1ns/1ps
`include "hold_reset_defines.vh"
module hold_reset_assertions
(
  input wire       mclk,
  input wire       rstn,
  input wire       button_n,
  input wire       enable_switch,
  input wire       card_present,
  input wire       image_present,
  input wire       key_valid,
  input wire       auth_done,
  input wire       auth_ok,
  input wire       app_stopped_ack,
  input wire       error_led,
  input wire [3:0] display_mode,
  input wire [2:0] display_digit,
  input wire       app_halt_req,
  input wire       restore_defaults,
  input wire       delete_user_files,
  input wire       module_reset,
  input wire       stay_stopped,
  input wire       log_valid,
  input wire [1:0] log_action
);
  reg       logged_reg;
  reg [1:0] last_act_reg;

  // Remembers the last logged action so the reset kind can be tied to it
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      logged_reg   <= 1'b0;
      last_act_reg <= 2'h0;
    end
    else if (log_valid)
    begin
      logged_reg   <= 1'b1;
      last_act_reg <= log_action;
    end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_halt_open;
    app_halt_req && !app_stopped_ack;
  endsequence

  sequence s_factory_held;
    display_mode == `DISP_PENDING_FACTORY_RESTORE && !button_n && enable_switch;
  endsequence

  a_led_power_up: assert property ($rose(rstn) |-> error_led)
    else $error("error led not on after power up");
  a_media_fail_led: assert property (error_led && !(card_present && image_present && key_valid)
    |=> error_led)
    else $error("error led dropped with boot media missing");
  a_auth_fail_led: assert property (error_led && auth_done && !auth_ok |=> error_led)
    else $error("error led dropped after failed authentication");
  a_scroll_led_off: assert property (display_mode == `DISP_SCROLL_POINT |-> !error_led)
    else $error("error led on while boot animation shown");
  a_button_ignored: assert property ((!enable_switch) [*3] |-> !log_valid
    && display_mode != `DISP_COUNTDOWN && display_mode != `DISP_PENDING_MODULE_RESET)
    else $error("button acted on while disabled");
  a_digit_range: assert property (display_mode == `DISP_COUNTDOWN
    |-> display_digit >= 3'h1 && display_digit <= 3'h4)
    else $error("countdown digit out of range");
  a_halt_first: assert property (s_halt_open |-> !$rose(module_reset))
    else $error("module reset before application halted");
  a_log_first: assert property ($rose(module_reset) |-> logged_reg || log_valid)
    else $error("module reset without log entry");
  a_log_action: assert property (log_valid |-> log_action != `ACT_NONE)
    else $error("log entry without action");
  a_factory_restores: assert property (delete_user_files && module_reset
    |-> restore_defaults)
    else $error("factory restore without configuration defaults");
  a_config_stays: assert property ($rose(module_reset) && last_act_reg == `ACT_CONFIG
    |-> ##[0:4] (restore_defaults && stay_stopped && !delete_user_files))
    else $error("configuration reset did not stay stopped");
  a_factory_held: assert property (s_factory_held
    |=> display_mode == `DISP_PENDING_FACTORY_RESTORE)
    else $error("factory code left while button held");
endmodule

bind hold_time_reset_selector hold_reset_assertions u_chk
(
  .mclk, .rstn, .button_n, .enable_switch, .card_present, .image_present, .key_valid,
  .auth_done, .auth_ok, .app_stopped_ack, .error_led, .display_mode, .display_digit,
  .app_halt_req, .restore_defaults, .delete_user_files, .module_reset, .stay_stopped,
  .log_valid, .log_action
);

// ===== sim/operator_panel.sv
`timescale 1ns/1ps
`include "hold_reset_defines.vh"
module operator_panel
(
  input  wire       mclk,
  input  wire       rstn,
  input  wire       app_halt_req,
  output reg        button_n,
  output reg        enable_switch,
  output reg        card_present,
  output reg        image_present,
  output reg        key_valid,
  output reg        auth_done,
  output reg        auth_ok,
  output reg  [1:0] app_state_in,
  output reg        app_stopped_ack
);
  int ack_delay = 5;
  int halt_cnt  = 0;
  reg halted    = 1'b0;

  initial
  begin
    button_n        = 1'b1;
    enable_switch   = 1'b0;
    {card_present, image_present, key_valid, auth_done, auth_ok} = 5'h1f;
    app_state_in    = `APP_STOP;
    app_stopped_ack = 1'b0;
  end

  // The application takes a few cycles to stop, so the halt request must wait
  always @(posedge mclk)
    if (!rstn)
      halted <= 1'b0;
    else if (!app_halt_req)
    begin
      halt_cnt        <= 0;
      app_stopped_ack <= 1'b0;
    end
    else if (halt_cnt < ack_delay)
      halt_cnt <= halt_cnt + 1;
    else
    begin
      app_stopped_ack <= 1'b1;
      app_state_in    <= `APP_STOP;
      halted          <= 1'b1;
    end

  task automatic set_media(input [3:0] m);
    {card_present, image_present, key_valid, auth_ok} <= m;
  endtask

  task automatic press(input bit en, input int n);
    begin
      enable_switch <= en;
      button_n      <= 1'b0;
      repeat (n) @(posedge mclk);
      button_n      <= 1'b1;
    end
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "hold_reset_defines.vh"
module testbench;
  // Shortened second and debounce so every hold case fits the run
  localparam int SEC = 400;
  localparam int DEB = 50;
  reg         mclk = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, app_state_set, log_action, app_state_in;
  wire [31:0] s_axi_rdata;
  wire [3:0]  display_mode;
  wire [2:0]  display_digit;
  wire        error_led, app_halt_req, app_store_req, restore_defaults, delete_user_files;
  wire        module_reset, stay_stopped, app_state_set_valid, log_valid;
  wire        button_n, enable_switch, card_present, image_present, key_valid;
  wire        auth_done, auth_ok, app_stopped_ack;
  int         fails = 0, cmp_count = 0, i;
  reg  [1:0]  log_seen, set_seen;
  reg         store_seen;
  reg  [4:0]  modes_seen;
  reg  [7:0]  digits_seen;
  reg  [4:0]  mode_tab [5] = '{5'h00, 5'h02, 5'h06, 5'h0e, 5'h1e};
  reg  [31:0] d;
  reg  [1:0]  r;
  reg  [3:0]  media_tab [5] = '{4'b0111, 4'b1011, 4'b1101, 4'b1110, 4'b1111};
  int         hold_tab [5] = '{7, 3, 7, 12, 17};
  bit         en_tab [5] = '{0, 1, 1, 1, 1};
  reg  [1:0]  act_tab [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};

  always #4 mclk = ~mclk;

  hold_time_reset_selector #(.SEC_LEN(SEC), .DEB_LEN(DEB)) dut
  (
    .mclk, .rstn, .button_n, .enable_switch, .card_present, .image_present, .key_valid,
    .auth_done, .auth_ok, .app_state_in, .app_stopped_ack, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .error_led, .display_mode, .display_digit,
    .app_halt_req, .app_store_req, .restore_defaults, .delete_user_files, .module_reset,
    .stay_stopped, .app_state_set, .app_state_set_valid, .log_valid, .log_action
  );

  operator_panel pnl
  (
    .mclk, .rstn, .app_halt_req, .button_n, .enable_switch, .card_present, .image_present,
    .key_valid, .auth_done, .auth_ok, .app_state_in, .app_stopped_ack
  );

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      log_seen    <= 2'h0;
      set_seen    <= 2'h3;
      store_seen  <= 1'b0;
      modes_seen  <= 5'h00;
      digits_seen <= 8'h00;
    end
    else
    begin
      if (app_state_set_valid) set_seen <= app_state_set;
      if (log_valid) log_seen <= log_action;
      if (app_store_req) store_seen <= 1'b1;
      if (display_mode >= `DISP_COUNTDOWN && display_mode <= `DISP_PENDING_FACTORY_RESTORE)
        modes_seen[display_mode] <= 1'b1;
      if (display_mode == `DISP_COUNTDOWN) digits_seen[display_digit] <= 1'b1;
    end
  end

  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        fails++;
        $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic lost;
    begin
      fails++;
      $display("unexpected at %0t: wait ran out", $time);
      summarize();
    end
  endtask

  task automatic axw(input [7:0] a, input [31:0] v, output [1:0] rr);
    int n;
    begin
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      rr = 2'h0;
      for (n = 0; n < 64; n++)
      begin
        @(posedge mclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
          rr = s_axi_bresp;
          s_axi_bready <= 1'b0;
          break;
        end
      end
      if (n == 64) lost();
    end
  endtask

  task automatic axr(input [7:0] a, output [31:0] dd, output [1:0] rr);
    int n;
    begin
      @(posedge mclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      dd = 32'h0000_0000;
      rr = 2'h0;
      for (n = 0; n < 64; n++)
      begin
        @(posedge mclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
          dd = s_axi_rdata;
          rr = s_axi_rresp;
          s_axi_rready <= 1'b0;
          break;
        end
      end
      if (n == 64) lost();
    end
  endtask

  task automatic wait_mode(input [3:0] m, input int lim);
    int n;
    begin
      for (n = 0; n < lim && display_mode !== m; n++)
        @(posedge mclk);
      if (n == lim) lost();
      chk(display_mode, m);
    end
  endtask

  task automatic boot(input [3:0] m);
    begin
      rstn <= 1'b0;
      pnl.set_media(m);
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chk(error_led, 1'b1);
    end
  endtask

  initial
  begin
    @(posedge mclk);
    for (i = 0; i < 5; i++)
    begin
      boot(media_tab[i]);
      repeat (200) @(posedge mclk);
      chk(error_led, i < 4);
      chk(display_mode == `DISP_SCROLL_POINT, i == 4);
    end
    axr(`REG_ID, d, r);
    chk(d, `ID_VALUE);
    axr(`REG_CTRL, d, r);
    chk(d, `CTRL_RESET_VAL);
    axw(`REG_IPADDR, 32'ha9fe_0102, r);
    axr(`REG_IPADDR, d, r);
    chk(d, 32'ha9fe_0102);
    axw(8'h40, 32'h0000_0001, r);
    chk(r, `RESP_SLVERR);
    axr(8'h40, d, r);
    chk(d, 32'h0000_0000);
    chk(r, `RESP_SLVERR);
    axw(`REG_VERSION, 32'h0000_0001, r);
    chk(r, `RESP_SLVERR);
    axw(`REG_CTRL, 32'h0000_0011, r);
    chk(r, `RESP_OKAY);
    wait_mode(`DISP_VERSION, 100);
    // Hold-time cases only fit the run when the second base is shortened
    if (SEC <= 800 && DEB <= 200)
    begin
      repeat (SEC + SEC / 2) @(posedge mclk);
      chk(display_mode, `DISP_VERSION);
      repeat (2 * SEC) @(posedge mclk);
      chk(display_mode, `DISP_AUTO_ADDRESS);
      chk(set_seen, `APP_RUN);
      for (i = 0; i < 5; i++)
      begin
        boot(4'b1111);
        wait_mode(`DISP_SCROLL_POINT, 1000);
        axw(`REG_CTRL, 32'h0000_0011, r);
        repeat (3 * SEC) @(posedge mclk);
        pnl.app_state_in <= `APP_RUN;
        pnl.press(en_tab[i], hold_tab[i] * SEC + SEC / 2 + DEB);
        repeat (4 * DEB + 200) @(posedge mclk);
        chk(log_seen, act_tab[i]);
        chk(module_reset, act_tab[i] != 0);
        chk(restore_defaults, act_tab[i] > 1);
        chk(delete_user_files, act_tab[i] == 3);
        chk(pnl.halted, act_tab[i] != 0);
        chk(store_seen, act_tab[i] > 1);
        chk(stay_stopped, act_tab[i] > 1);
        chk(modes_seen, mode_tab[i]);
        // A hold of three and a half seconds may or may not reach digit 1
        chk(digits_seen | (i == 1 ? 8'h02 : 8'h00), i > 0 ? 8'h1e : 8'h00);
      end
    end
    summarize();
  end
endmodule
